// [rtl/nv_access_cfg.svh]
// Constants for the non-volatile byte access block.
// Included by the package and by each design file but the array interface; definitions only.
`ifndef NV_ACCESS_CFG_SVH
`define NV_ACCESS_CFG_SVH
`define NV_DEPTH 64
`define NV_AW 6
`define NV_DW 8
`define NV_PTR_ADDR 8'h1E
`define NV_VAL_ADDR 8'h1F
`define NV_CTL_ADDR 8'h40
`define NV_CTL_BANK 1'b1
`define NV_DATA_BANK 1'b0
`define CTL_PROG_EN 3
`define CTL_PROG_GO 2
`define CTL_READ_EN 1
`define CTL_READ_GO 0
`define NV_RST_BYTE 8'h00
`define NV_RST_PTR 6'h00
`define NV_READ_CYCLES 4'h4
`define NV_CNT_W 4
`define NV_ZERO_CNT 4'h0
`define NV_ONE_CNT 4'h1
`define NV_TWO_CNT 4'h2
`define PROG_TIME_NS 2000
`define CLK_PERIOD_NS 4
`define PROG_TICKS_DEFAULT 16'h0100
`define PROG_TMR_W 16
`endif

// [rtl/nv_access_pkg.sv]
// Types shared by the non-volatile byte access design files.
// Assumes nv_access_cfg.svh sits on the include path.
`include "nv_access_cfg.svh"
package nv_access_pkg;
  typedef enum logic [1:0] {
    st_idle,
    st_read,
    st_prog
  } nv_state_t;
  typedef logic [`NV_AW-1:0] nv_addr_t;
  typedef logic [`NV_DW-1:0] nv_byte_t;
endpackage : nv_access_pkg

// [rtl/nv_array_if.sv]
// Carrier between the access controller and the storage array.
// Assumes both ends share clk_sys.
`timescale 1ns/100ps
interface nv_array_if;
  import nv_access_pkg::*;
  logic rd_stb;
  logic wr_stb;
  nv_addr_t addr;
  nv_byte_t wdata;
  nv_byte_t rdata;
  modport ctrl (output rd_stb, output wr_stb, output addr, output wdata, input rdata);
  modport mem (input rd_stb, input wr_stb, input addr, input wdata, output rdata);
endinterface : nv_array_if

// [rtl/nv_store_array.sv]
// The 64x8 byte store itself, one byte per access.
// Assumes strobes from the controller; contents undefined after power-up.
`timescale 1ns/100ps
`include "nv_access_cfg.svh"
module nv_store_array
  import nv_access_pkg::*;
(
  input wire logic clk_sys,
  nv_array_if.mem bus
);
  nv_byte_t mem_q [`NV_DEPTH];
  nv_byte_t rdata_q;

  always_ff @(posedge clk_sys) begin
    if (bus.wr_stb) begin
      mem_q[bus.addr] <= bus.wdata;
    end
    if (bus.rd_stb) begin
      rdata_q <= mem_q[bus.addr];
    end
  end
  assign bus.rdata = rdata_q;
endmodule : nv_store_array

// [rtl/nv_prog_timer.sv]
// Program-cycle timer; stands in for a free-running timer unrelated to the
// system clock, so the cycle count seen by software is not to be relied on.
`timescale 1ns/100ps
`include "nv_access_cfg.svh"
module nv_prog_timer #(
  parameter logic [`PROG_TMR_W-1:0] TICKS = `PROG_TICKS_DEFAULT
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic start,
  output logic done
);
  logic [`PROG_TMR_W-1:0] cnt_q, cnt_d;
  logic run_q, run_d;
  logic done_q, done_d;

  always_comb begin
    cnt_d = cnt_q;
    run_d = run_q;
    done_d = 1'b0;
    if (start && !run_q) begin
      run_d = 1'b1;
      cnt_d = TICKS;
    end else if (run_q) begin
      if (cnt_q <= {{(`PROG_TMR_W-1){1'b0}}, 1'b1}) begin
        run_d = 1'b0;
        done_d = 1'b1;
      end else begin
        cnt_d = cnt_q - {{(`PROG_TMR_W-1){1'b0}}, 1'b1};
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
      run_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      run_q <= run_d;
      done_q <= done_d;
    end
  end
  assign done = done_q;
endmodule : nv_prog_timer

// [rtl/nv_byte_access.sv]
// Access controller for the 64x8 non-volatile data array.
// Assumes the core presents one special-register access per cycle with
// the bank already resolved (indirect accesses arrive with sfr_bank).
`timescale 1ns/100ps
`include "nv_access_cfg.svh"

// Overview of operation
// - 64 bytes, addresses 0 to 63
// - One byte per access; bank decoded for control only
// - Control register only at bank 1, 40H
// - Pointer six bits, upper bits read zero
// - Value register eight bits, cleared at reset
// - Control bits 3..0, upper read zero
// - Program blocked while program permit low
// - Program start self-clears at completion
// - Program start ignored without prior permit
// - Read blocked while fetch permit low
// - Read start self-clears at completion
// - Read start ignored without prior permit
// - Fetched byte lands in value register
// - Fetched byte held until next operation
// - Program cycle timed by independent timer
// - Program completion raises done and multi-function flags
module nv_byte_access
  import nv_access_pkg::*;
#(
  parameter logic [`PROG_TMR_W-1:0] PROG_TICKS = `PROG_TICKS_DEFAULT
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_bank,
  input wire logic [7:0] sfr_wdata,
  input wire logic done_flag_clr,
  output logic [7:0] sfr_rdata,
  output logic sfr_hit,
  output logic nv_done_flag,
  output logic multi_func_flag
);
  nv_array_if arr ();
  logic prog_done;

  nv_store_array u_array (
    .clk_sys(clk_sys),
    .bus(arr.mem)
  );

  nv_prog_timer #(.TICKS(PROG_TICKS)) u_timer (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .start(arr.wr_stb),
    .done(prog_done)
  );

  nv_state_t state_q, state_d;
  nv_addr_t ptr_q, ptr_d;
  nv_byte_t val_q, val_d;
  logic prog_en_q, prog_en_d, prog_go_q, prog_go_d;
  logic read_en_q, read_en_d, read_go_q, read_go_d;
  logic [`NV_CNT_W-1:0] cnt_q, cnt_d;
  logic rd_stb_q, rd_stb_d, wr_stb_q, wr_stb_d;
  logic done_q, done_d, mf_q, mf_d;
  logic [7:0] rdata_q, rdata_d;
  logic hit_q, hit_d;
  logic wr_ptr, wr_val, wr_ctl, busy;

  // Pointer/value decoded in either bank; control only in bank 1
  assign wr_ptr = sfr_wr && (sfr_addr == `NV_PTR_ADDR);
  assign wr_val = sfr_wr && (sfr_addr == `NV_VAL_ADDR);
  assign wr_ctl = sfr_wr && (sfr_addr == `NV_CTL_ADDR) && (sfr_bank == `NV_CTL_BANK);
  assign busy = (state_q != st_idle);

  always_comb begin
    state_d = state_q;
    ptr_d = ptr_q;
    val_d = val_q;
    prog_en_d = prog_en_q;
    prog_go_d = prog_go_q;
    read_en_d = read_en_q;
    read_go_d = read_go_q;
    cnt_d = cnt_q;
    rd_stb_d = 1'b0;
    wr_stb_d = 1'b0;
    // Address and data frozen while a cycle runs
    if (wr_ptr && !busy) begin
      ptr_d = sfr_wdata[`NV_AW-1:0];
    end
    if (wr_val && !busy) begin
      val_d = sfr_wdata;
    end
    if (wr_ctl) begin
      prog_en_d = sfr_wdata[`CTL_PROG_EN];
      read_en_d = sfr_wdata[`CTL_READ_EN];
    end
    case (state_q)
      st_idle: begin
        // Enables must already be high: permit is the stored value
        if (wr_ctl && sfr_wdata[`CTL_PROG_GO] && prog_en_q) begin
          prog_go_d = 1'b1;
          wr_stb_d = 1'b1;
          state_d = st_prog;
        end else if (wr_ctl && sfr_wdata[`CTL_READ_GO] && read_en_q) begin
          read_go_d = 1'b1;
          cnt_d = `NV_READ_CYCLES;
          state_d = st_read;
        end
      end
      st_read: begin
        // Array output is registered: strobe two edges ahead of the load
        if (cnt_q == `NV_TWO_CNT) begin
          rd_stb_d = 1'b1;
        end
        if (cnt_q == `NV_ZERO_CNT) begin
          val_d = arr.rdata;
          read_go_d = 1'b0;
          state_d = st_idle;
        end else begin
          cnt_d = cnt_q - `NV_ONE_CNT;
        end
      end
      st_prog: begin
        if (prog_done) begin
          prog_go_d = 1'b0;
          state_d = st_idle;
        end
      end
      default: begin
        state_d = st_idle;
      end
    endcase
  end

  always_comb begin
    // Set beats clear for the completion flags
    done_d = done_q;
    mf_d = mf_q;
    if (done_flag_clr) begin
      done_d = 1'b0;
      mf_d = 1'b0;
    end
    if (prog_done) begin
      done_d = 1'b1;
      mf_d = 1'b1;
    end
    rdata_d = 8'h00;
    hit_d = 1'b0;
    if (sfr_rd) begin
      if (sfr_addr == `NV_PTR_ADDR) begin
        rdata_d = {2'h0, ptr_q};
        hit_d = 1'b1;
      end else if (sfr_addr == `NV_VAL_ADDR) begin
        rdata_d = val_q;
        hit_d = 1'b1;
      end else if (sfr_addr == `NV_CTL_ADDR && sfr_bank == `NV_CTL_BANK) begin
        rdata_d = {4'h0, prog_en_q, prog_go_q, read_en_q, read_go_q};
        hit_d = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= st_idle;
      ptr_q <= `NV_RST_PTR;
      val_q <= `NV_RST_BYTE;
      prog_en_q <= 1'b0;
      prog_go_q <= 1'b0;
      read_en_q <= 1'b0;
      read_go_q <= 1'b0;
      cnt_q <= `NV_ZERO_CNT;
      rd_stb_q <= 1'b0;
      wr_stb_q <= 1'b0;
      done_q <= 1'b0;
      mf_q <= 1'b0;
      rdata_q <= 8'h00;
      hit_q <= 1'b0;
    end else begin
      state_q <= state_d;
      ptr_q <= ptr_d;
      val_q <= val_d;
      prog_en_q <= prog_en_d;
      prog_go_q <= prog_go_d;
      read_en_q <= read_en_d;
      read_go_q <= read_go_d;
      cnt_q <= cnt_d;
      rd_stb_q <= rd_stb_d;
      wr_stb_q <= wr_stb_d;
      done_q <= done_d;
      mf_q <= mf_d;
      rdata_q <= rdata_d;
      hit_q <= hit_d;
    end
  end

  assign arr.rd_stb = rd_stb_q;
  assign arr.wr_stb = wr_stb_q;
  assign arr.addr = ptr_q;
  assign arr.wdata = val_q;
  assign sfr_rdata = rdata_q;
  assign sfr_hit = hit_q;
  assign nv_done_flag = done_q;
  assign multi_func_flag = mf_q;

  sequence s_read_go;
    state_q == st_idle && wr_ctl && sfr_wdata[`CTL_READ_GO] && read_en_q;
  endsequence
  sequence s_read_busy;
    read_go_q [*5];
  endsequence

  a_read_start_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_read_go |=> s_read_busy ##1 !read_go_q)
    else $error("read start not held for fixed latency");
  a_read_no_permit: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state_q == st_idle && !read_en_q && !prog_en_q) |=> !read_go_q && !prog_go_q)
    else $error("start taken without permit");
  a_prog_no_permit: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state_q == st_idle && !prog_en_q) |=> !wr_stb_q)
    else $error("program cycle without permit");
  a_prog_clear_done: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (prog_go_q && prog_done) |=> !prog_go_q && nv_done_flag)
    else $error("program start not cleared at completion");
  a_done_flags_pair: assert property (@(posedge clk_sys) disable iff (!rst_n)
    prog_done |=> nv_done_flag && multi_func_flag)
    else $error("completion flags not raised");
  a_value_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (busy && !$past(busy)) |-> $stable(val_q))
    else $error("value changed at cycle start");
  a_ptr_frozen: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (busy && wr_ptr) |=> $stable(ptr_q))
    else $error("pointer changed during cycle");
  a_ptr_upper_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (sfr_rd && sfr_addr == `NV_PTR_ADDR) |=> sfr_rdata[7:6] == 2'h0 && sfr_hit)
    else $error("pointer upper bits not zero");
  a_ctl_bank_only: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (sfr_rd && sfr_addr == `NV_CTL_ADDR && sfr_bank != `NV_CTL_BANK) |=> !sfr_hit)
    else $error("control answered outside bank 1");
  a_ctl_upper_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
    sfr_hit |-> !(sfr_rdata[7:4] != 4'h0 && $past(sfr_addr) == `NV_CTL_ADDR))
    else $error("control upper bits not zero");

  // Load must see the array byte fetched by the strobe, not an older one
  sequence s_prog_go;
    state_q == st_idle && wr_ctl && sfr_wdata[`CTL_PROG_GO] && prog_en_q;
  endsequence
  sequence s_fetch_load;
    (state_q == st_read && cnt_q == `NV_ONE_CNT) ##1
    (state_q == st_read && cnt_q == `NV_ZERO_CNT) ##1
    (state_q == st_idle && val_q == $past(arr.rdata));
  endsequence

  a_prog_go_launch: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_prog_go |=> prog_go_q && wr_stb_q)
    else $error("program start not launched");
  a_rd_stb_timing: assert property (@(posedge clk_sys) disable iff (!rst_n)
    rd_stb_q |-> s_fetch_load)
    else $error("fetched byte not loaded after strobe");
  a_wr_stb_pulse: assert property (@(posedge clk_sys) disable iff (!rst_n)
    wr_stb_q |=> !wr_stb_q)
    else $error("array write strobe longer than one cycle");
  a_rd_stb_pulse: assert property (@(posedge clk_sys) disable iff (!rst_n)
    rd_stb_q |=> !rd_stb_q)
    else $error("array read strobe longer than one cycle");
  a_busy_ptr_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
    busy |=> $stable(ptr_q))
    else $error("pointer moved while busy");
  a_prog_val_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state_q == st_prog) |=> $stable(val_q))
    else $error("value moved during program cycle");
  a_read_val_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state_q == st_read && cnt_q != `NV_ZERO_CNT) |=> $stable(val_q))
    else $error("value moved before read load");
  a_prog_blocks_read: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state_q == st_prog && wr_ctl) |=> !read_go_q)
    else $error("read started during program cycle");
  a_read_blocks_prog: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state_q == st_read && wr_ctl) |=> !wr_stb_q && !prog_go_q)
    else $error("program started during read cycle");
  a_done_in_prog: assert property (@(posedge clk_sys) disable iff (!rst_n)
    prog_done |-> state_q == st_prog)
    else $error("timer completion outside program cycle");
  a_done_sticky: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (nv_done_flag && !done_flag_clr) |=> nv_done_flag)
    else $error("done flag dropped without clear");
  a_flag_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (done_flag_clr && !prog_done) |=> !nv_done_flag && !multi_func_flag)
    else $error("completion flags not cleared");
  a_permit_follow: assert property (@(posedge clk_sys) disable iff (!rst_n)
    wr_ctl |=> prog_en_q == $past(sfr_wdata[`CTL_PROG_EN]) && read_en_q == $past(sfr_wdata[`CTL_READ_EN]))
    else $error("permit bits not written");
  a_rdata_idle_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !sfr_rd |=> sfr_rdata == 8'h00 && !sfr_hit)
    else $error("read data without read");
  a_idle_go_low: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state_q == st_idle) |-> !read_go_q && !prog_go_q)
    else $error("start bit high while idle");
  a_read_go_state: assert property (@(posedge clk_sys) disable iff (!rst_n)
    read_go_q |-> state_q == st_read)
    else $error("read start high outside read cycle");
endmodule : nv_byte_access

// [sim/core_model.sv]
// Model of the core that issues single-byte register accesses.
// Assumes the design samples on the rising edge; drives change at the falling edge.
`timescale 1ns/100ps
module core_model (
  input wire logic clk_sys,
  output logic sfr_wr,
  output logic sfr_rd,
  output logic [7:0] sfr_addr,
  output logic sfr_bank,
  output logic [7:0] sfr_wdata,
  output logic done_flag_clr,
  input wire logic [7:0] sfr_rdata,
  input wire logic sfr_hit
);
  initial begin
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    sfr_addr = 8'h00;
    sfr_bank = 1'b0;
    sfr_wdata = 8'h00;
    done_flag_clr = 1'b0;
  end
  // Bank comes with the access, as the indirect path resolves it
  task automatic wr(input logic [7:0] a, input logic b, input logic [7:0] d);
    @(negedge clk_sys);
    sfr_addr = a;
    sfr_bank = b;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge clk_sys);
    sfr_wr = 1'b0;
    // Released data line shows no stale byte
    sfr_wdata = ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic b, output logic [7:0] d, output logic h);
    @(negedge clk_sys);
    sfr_addr = a;
    sfr_bank = b;
    sfr_rd = 1'b1;
    @(negedge clk_sys);
    sfr_rd = 1'b0;
    d = sfr_rdata;
    h = sfr_hit;
  endtask : rd
  task automatic clr();
    @(negedge clk_sys);
    done_flag_clr = 1'b1;
    @(negedge clk_sys);
    done_flag_clr = 1'b0;
  endtask : clr
endmodule : core_model

// [sim/nv_byte_access_tb_top.sv]
// Self-checking bench for the non-volatile byte access controller.
// Assumes the shared cfg header on the include path; core_model drives the bus.
`timescale 1ns/100ps
`include "nv_access_cfg.svh"
module nv_byte_access_tb_top;
  logic clk_sys;
  logic rst_n;
  logic sfr_wr;
  logic sfr_rd;
  logic [7:0] sfr_addr;
  logic sfr_bank;
  logic [7:0] sfr_wdata;
  logic done_flag_clr;
  logic [7:0] sfr_rdata;
  logic sfr_hit;
  logic nv_done_flag;
  logic multi_func_flag;
  int num_errors;
  int cmp_count;
  logic [7:0] addrs [2] = '{8'h00, 8'h3F};
  logic [7:0] bytes [2] = '{8'h5A, 8'hC3};
  nv_byte_access #(.PROG_TICKS(16'h0008)) nv_byte_access_i (
    .clk_sys(clk_sys), .rst_n(rst_n), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_addr(sfr_addr), .sfr_bank(sfr_bank), .sfr_wdata(sfr_wdata),
    .done_flag_clr(done_flag_clr), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit),
    .nv_done_flag(nv_done_flag), .multi_func_flag(multi_func_flag)
  );
  core_model core_model_i (
    .clk_sys(clk_sys), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_addr(sfr_addr),
    .sfr_bank(sfr_bank), .sfr_wdata(sfr_wdata), .done_flag_clr(done_flag_clr),
    .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit)
  );
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic rdc(input logic [7:0] a, input logic b, input logic [7:0] e, input logic he);
    logic [7:0] d;
    logic h;
    core_model_i.rd(a, b, d, h);
    chk(d, e);
    chk({7'h00, h}, {7'h00, he});
  endtask : rdc
  // Bounded poll of a self-clearing start bit
  task automatic poll(input logic [7:0] m);
    logic [7:0] d;
    logic h;
    for (int i = 0; i < 64; i++) begin
      core_model_i.rd(`NV_CTL_ADDR, 1'b1, d, h);
      if ((d & m) === 8'h00) break;
    end
    chk(d & m, 8'h00);
  endtask : poll
  task automatic tally_and_finish();
    $display("Comparisons %0d, errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : tally_and_finish
  task automatic fetch(input logic [7:0] a, input logic [7:0] e);
    core_model_i.wr(`NV_VAL_ADDR, 1'b0, 8'h00);
    core_model_i.wr(`NV_PTR_ADDR, 1'b0, a);
    core_model_i.wr(`NV_CTL_ADDR, 1'b1, 8'h02);
    core_model_i.wr(`NV_CTL_ADDR, 1'b1, 8'h03);
    rdc(`NV_CTL_ADDR, 1'b1, 8'h03, 1'b1);
    poll(8'h01);
    rdc(`NV_VAL_ADDR, 1'b0, e, 1'b1);
    core_model_i.wr(`NV_PTR_ADDR, 1'b0, ~a & 8'h3F);
    rdc(`NV_VAL_ADDR, 1'b0, e, 1'b1);
  endtask : fetch
  initial begin
    #100000;
    num_errors++;
    $display("ERROR %0t watchdog expired", $time);
    tally_and_finish();
  end
  initial begin
    num_errors = 0;
    cmp_count = 0;
    rst_n = 1'b0;
    repeat (10) @(negedge clk_sys);
    rst_n = 1'b1;
    rdc(`NV_PTR_ADDR, 1'b0, 8'h00, 1'b1);
    rdc(`NV_VAL_ADDR, 1'b0, 8'h00, 1'b1);
    rdc(`NV_CTL_ADDR, 1'b1, 8'h00, 1'b1);
    rdc(8'h20, 1'b0, 8'h00, 1'b0);
    core_model_i.wr(`NV_PTR_ADDR, 1'b0, 8'hFF);
    rdc(`NV_PTR_ADDR, 1'b0, 8'h3F, 1'b1);
    core_model_i.wr(`NV_CTL_ADDR, 1'b0, 8'h02);
    rdc(`NV_CTL_ADDR, 1'b0, 8'h00, 1'b0);
    rdc(`NV_CTL_ADDR, 1'b1, 8'h00, 1'b1);
    // Enable and start in one write: only the enable lands
    core_model_i.wr(`NV_CTL_ADDR, 1'b1, 8'hFC);
    rdc(`NV_CTL_ADDR, 1'b1, 8'h08, 1'b1);
    core_model_i.wr(`NV_CTL_ADDR, 1'b1, 8'h03);
    rdc(`NV_CTL_ADDR, 1'b1, 8'h02, 1'b1);
    chk({6'h00, nv_done_flag, multi_func_flag}, 8'h00);
    for (int k = 0; k < 2; k++) begin
      core_model_i.wr(`NV_PTR_ADDR, 1'b0, addrs[k]);
      core_model_i.wr(`NV_VAL_ADDR, 1'b0, bytes[k]);
      core_model_i.wr(`NV_CTL_ADDR, 1'b1, 8'h08);
      core_model_i.wr(`NV_CTL_ADDR, 1'b1, 8'h0C);
      rdc(`NV_CTL_ADDR, 1'b1, 8'h0C, 1'b1);
      core_model_i.wr(`NV_VAL_ADDR, 1'b0, ~bytes[k]);
      poll(8'h04);
      chk({6'h00, nv_done_flag, multi_func_flag}, 8'h03);
      core_model_i.clr();
      chk({6'h00, nv_done_flag, multi_func_flag}, 8'h00);
      rdc(`NV_VAL_ADDR, 1'b0, bytes[k], 1'b1);
      fetch(addrs[k], bytes[k]);
      core_model_i.wr(`NV_CTL_ADDR, 1'b1, 8'h00);
    end
    // Starts with enables low must leave array and value alone
    core_model_i.wr(`NV_CTL_ADDR, 1'b1, 8'h04);
    chk({6'h00, nv_done_flag, multi_func_flag}, 8'h00);
    core_model_i.wr(`NV_CTL_ADDR, 1'b1, 8'h01);
    rdc(`NV_CTL_ADDR, 1'b1, 8'h00, 1'b1);
    rdc(`NV_VAL_ADDR, 1'b0, 8'hC3, 1'b1);
    fetch(8'h00, 8'h5A);
    tally_and_finish();
  end
endmodule : nv_byte_access_tb_top
